// file: dsr_pkg.sv
// package: offsets, reset values and carriers for the system register bank
package dsr_pkg;
  localparam int unsigned AW = 11;
  localparam int unsigned DW = 32;
  // region bounds of the 2 KB configuration space
  localparam logic [10:0] REG_CTRL_LO  = 11'h000;
  localparam logic [10:0] REG_CTRL_HI  = 11'h1FC;
  localparam logic [10:0] REG_PHY_LO   = 11'h200;
  localparam logic [10:0] REG_PHY_HI   = 11'h3FC;
  localparam logic [10:0] REG_FIC_LO   = 11'h400;
  localparam logic [10:0] REG_FIC_HI   = 11'h4FC;
  localparam logic [10:0] REG_SYS_LO   = 11'h500;
  localparam logic [10:0] REG_SYS_HI   = 11'h5FC;
  localparam logic [10:0] REG_RSV_LO   = 11'h600;
  localparam logic [10:0] REG_RSV_HI   = 11'h7FC;
  // system register offsets
  localparam logic [10:0] OFS_PLL_LOW_A   = 11'h500;
  localparam logic [10:0] OFS_PLL_LOW_B   = 11'h504;
  localparam logic [10:0] OFS_PLL_UPPER   = 11'h508;
  localparam logic [10:0] OFS_CLK_GATE    = 11'h50C;
  localparam logic [10:0] OFS_MUX_SEL     = 11'h510;
  localparam logic [10:0] OFS_RATIO       = 11'h514;
  localparam logic [10:0] OFS_DELAY_SEL   = 11'h518;
  localparam logic [10:0] OFS_SOFT_RST    = 11'h51C;
  localparam logic [10:0] OFS_CAL_CTRL    = 11'h520;
  localparam logic [10:0] OFS_IRQ_EN      = 11'h524;
  localparam logic [10:0] OFS_BUS_SEL     = 11'h528;
  localparam logic [10:0] OFS_AUTO_CAL    = 11'h52C;
  localparam logic [10:0] OFS_SPLL_LOCK   = 11'h530;
  localparam logic [10:0] OFS_SUBSYSTEM_PLL_LOCK   = 11'h534;
  localparam logic [10:0] OFS_IRQ_STAT    = 11'h53C;
  localparam logic [10:0] OFS_CAL_STAT    = 11'h544;
  localparam logic [10:0] OFS_ALIGN_RST   = 11'h548;
  localparam logic [10:0] OFS_LOCK_CTRL   = 11'h5F8;
  // reset values
  localparam logic [31:0] RST_PLL_LOW_B = 32'h0000_000A;
  localparam logic [31:0] RST_PLL_UPPER = 32'h0000_3F80;
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;
  // interrupt event bit positions
  localparam int unsigned IRQ_N          = 4;
  localparam int unsigned IRQ_SPLL_CHG   = 0;
  localparam int unsigned IRQ_SUBSYSTEM_PLL_CHG   = 1;
  localparam int unsigned IRQ_CAL_DONE   = 2;
  localparam int unsigned IRQ_LOCK_WR    = 3;
  localparam int unsigned CAL_DONE_BIT   = 0;
  // control words driven into the subsystem
  typedef struct packed {
    logic [31:0] pll_low_a;
    logic [31:0] pll_low_b;
    logic [31:0] pll_upper;
    logic [31:0] clk_gate;
    logic [31:0] mux_sel;
    logic [31:0] ratio;
    logic [31:0] delay_sel;
    logic [31:0] soft_rst;
    logic [31:0] cal_ctrl;
    logic [31:0] bus_sel;
    logic [31:0] auto_cal;
    logic [31:0] align_rst;
  } dsr_ctrl_t;
  // status gathered from the subsystem
  typedef struct packed {
    logic        spll_lock;
    logic        subsystem_pll_lock;
    logic [31:0] cal_stat;
  } dsr_stat_t;
  typedef enum logic [1:0] {
    REGION_SYS  = 2'b00,
    REGION_SUB  = 2'b01,
    REGION_RSV  = 2'b10
  } dsr_region_t;
endpackage : dsr_pkg

// file: dsr_bank.sv
// system register bank with region decode on an Avalon-MM slave
//
// What this block does
// - decode controller, PHY, fabric-interface ranges together as one subsystem region
// - system group range; reserved range above it
// - lock bit blocks writes to system group
// - three PLL words drive PLL configuration
// - register gates controller clock
// - register selects alignment clock mux settings
// - register sets base to fabric clock ratio
// - register selects PLL delay line value
// - soft reset register holds subsystem
// - I/O calibration control register
// - register selects AXI or AHB fabric bus
// - register enables PHY automatic calibration lock
// - read-only subsystem PLL lock status
// - read-only fabric PLL lock status
// - read-only I/O calibration status
// - register drives alignment test circuit reset
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
module dsr_bank
  import dsr_pkg::*;
(
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_b,
  // avalon-mm slave
  input  wire logic [AW-1:0]     i_address,
  input  wire logic              i_read,
  input  wire logic              i_write,
  input  wire logic [DW-1:0]     i_writedata,
  input  wire logic [3:0]        i_byteenable,
  output logic [DW-1:0]          o_readdata,
  output logic                   o_waitrequest,
  output logic [1:0]             o_response,
  // subsystem side
  input  wire logic              i_spll_lock,
  input  wire logic              i_subsystem_pll_lock,
  input  wire logic [DW-1:0]     i_cal_stat,
  output dsr_ctrl_t              o_ctrl,
  output logic                   o_sub_sel,
  output logic                   o_irq
);

  dsr_ctrl_t         ctrl_q;
  logic [DW-1:0]     irq_en_q;
  logic [IRQ_N-1:0]  irq_st_q;
  logic              lock_q;
  logic              ack_q;
  logic              waitreq_q;
  logic [DW-1:0]     rdata_q;
  logic              sub_sel_q;
  logic              irq_q;
  logic [2:0]        spll_s_q;
  logic [2:0]        subsystem_pll_s_q;
  logic [DW-1:0]     cal_s1_q;
  logic [DW-1:0]     cal_s2_q;
  logic [DW-1:0]     cal_s3_q;
  dsr_stat_t         stat_q;
  logic [DW-1:0]     wmask;
  logic              req;
  logic              wr_go;
  logic              rd_go;
  logic              sys_wr;
  dsr_region_t       region;
  logic [IRQ_N-1:0]  ev;

  assign req   = i_read | i_write;
  // writes land at the edge that samples waitrequest low
  assign wr_go = i_write & ack_q;
  assign rd_go = i_read & ~ack_q;

  always_comb begin
    if (i_address >= REG_SYS_LO && i_address <= REG_SYS_HI) begin
      region = REGION_SYS;
    end else if (i_address <= REG_FIC_HI) begin
      region = REGION_SUB;
    end else begin
      region = REGION_RSV;
    end
  end

  // byte lane mask
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign wmask[gb*8 +: 8] = {8{i_byteenable[gb]}};
    end
  endgenerate

  assign sys_wr = wr_go & (region == REGION_SYS) & ~lock_q;

  // bus handshake: one wait cycle then answer
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_q     <= 1'b0;
      waitreq_q <= 1'b1;
    end else begin
      ack_q     <= req & ~ack_q;
      waitreq_q <= ~(req & ~ack_q);
    end
  end

  assign o_waitrequest = waitreq_q;

  // three-stage input sampling
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      spll_s_q <= 3'h0;
      subsystem_pll_s_q <= 3'h0;
      cal_s1_q <= RST_ZERO;
      cal_s2_q <= RST_ZERO;
      cal_s3_q <= RST_ZERO;
    end else begin
      spll_s_q <= {spll_s_q[1:0], i_spll_lock};
      subsystem_pll_s_q <= {subsystem_pll_s_q[1:0], i_subsystem_pll_lock};
      cal_s1_q <= i_cal_stat;
      cal_s2_q <= cal_s1_q;
      cal_s3_q <= cal_s2_q;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat_q <= '0;
    end else begin
      if (spll_s_q[1] == spll_s_q[2]) begin
        stat_q.spll_lock <= spll_s_q[2];
      end
      if (subsystem_pll_s_q[1] == subsystem_pll_s_q[2]) begin
        stat_q.subsystem_pll_lock <= subsystem_pll_s_q[2];
      end
      if (cal_s2_q == cal_s3_q) begin
        stat_q.cal_stat <= cal_s3_q;
      end
    end
  end

  // interrupt events
  always_comb begin
    ev = '0;
    ev[IRQ_SPLL_CHG] = (spll_s_q[1] == spll_s_q[2])
                       & (spll_s_q[2] != stat_q.spll_lock);
    ev[IRQ_SUBSYSTEM_PLL_CHG] = (subsystem_pll_s_q[1] == subsystem_pll_s_q[2])
                       & (subsystem_pll_s_q[2] != stat_q.subsystem_pll_lock);
    ev[IRQ_CAL_DONE] = (cal_s2_q == cal_s3_q)
                       & cal_s3_q[CAL_DONE_BIT]
                       & ~stat_q.cal_stat[CAL_DONE_BIT];
    ev[IRQ_LOCK_WR]  = wr_go & (region == REGION_SYS) & lock_q
                       & (i_address != OFS_LOCK_CTRL);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q           <= '0;
      ctrl_q.pll_low_b <= RST_PLL_LOW_B;
      ctrl_q.pll_upper <= RST_PLL_UPPER;
      irq_en_q         <= RST_ZERO;
    end else if (sys_wr) begin
      case (i_address)
        OFS_PLL_LOW_A: ctrl_q.pll_low_a <=
          (ctrl_q.pll_low_a & ~wmask) | (i_writedata & wmask);
        OFS_PLL_LOW_B: ctrl_q.pll_low_b <=
          (ctrl_q.pll_low_b & ~wmask) | (i_writedata & wmask);
        OFS_PLL_UPPER: ctrl_q.pll_upper <=
          (ctrl_q.pll_upper & ~wmask) | (i_writedata & wmask);
        OFS_CLK_GATE:  ctrl_q.clk_gate <=
          (ctrl_q.clk_gate & ~wmask) | (i_writedata & wmask);
        OFS_MUX_SEL:   ctrl_q.mux_sel <=
          (ctrl_q.mux_sel & ~wmask) | (i_writedata & wmask);
        OFS_RATIO:     ctrl_q.ratio <=
          (ctrl_q.ratio & ~wmask) | (i_writedata & wmask);
        OFS_DELAY_SEL: ctrl_q.delay_sel <=
          (ctrl_q.delay_sel & ~wmask) | (i_writedata & wmask);
        OFS_SOFT_RST:  ctrl_q.soft_rst <=
          (ctrl_q.soft_rst & ~wmask) | (i_writedata & wmask);
        OFS_CAL_CTRL:  ctrl_q.cal_ctrl <=
          (ctrl_q.cal_ctrl & ~wmask) | (i_writedata & wmask);
        OFS_IRQ_EN:    irq_en_q <=
          (irq_en_q & ~wmask) | (i_writedata & wmask);
        OFS_BUS_SEL:   ctrl_q.bus_sel <=
          (ctrl_q.bus_sel & ~wmask) | (i_writedata & wmask);
        OFS_AUTO_CAL:  ctrl_q.auto_cal <=
          (ctrl_q.auto_cal & ~wmask) | (i_writedata & wmask);
        OFS_ALIGN_RST: ctrl_q.align_rst <=
          (ctrl_q.align_rst & ~wmask) | (i_writedata & wmask);
        default: ;
      endcase
    end
  end

  // lock bit: always writable, bit 0
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lock_q <= 1'b0;
    end else if (wr_go && i_address == OFS_LOCK_CTRL && i_byteenable[0]) begin
      lock_q <= i_writedata[0];
    end
  end

  // sticky status, set wins over read clear
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_st_q <= '0;
    end else if (rd_go && i_address == OFS_IRQ_STAT) begin
      irq_st_q <= ev;
    end else begin
      irq_st_q <= irq_st_q | ev;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_st_q & irq_en_q[IRQ_N-1:0]);
    end
  end

  // read data mux
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q   <= RD_UNMAPPED;
      sub_sel_q <= 1'b0;
    end else begin
      sub_sel_q <= req & ~ack_q & (region == REGION_SUB);
      rdata_q   <= RD_UNMAPPED;
      if (rd_go) begin
        case (i_address)
          OFS_PLL_LOW_A: rdata_q <= ctrl_q.pll_low_a;
          OFS_PLL_LOW_B: rdata_q <= ctrl_q.pll_low_b;
          OFS_PLL_UPPER: rdata_q <= ctrl_q.pll_upper;
          OFS_CLK_GATE:  rdata_q <= ctrl_q.clk_gate;
          OFS_MUX_SEL:   rdata_q <= ctrl_q.mux_sel;
          OFS_RATIO:     rdata_q <= ctrl_q.ratio;
          OFS_DELAY_SEL: rdata_q <= ctrl_q.delay_sel;
          OFS_SOFT_RST:  rdata_q <= ctrl_q.soft_rst;
          OFS_CAL_CTRL:  rdata_q <= ctrl_q.cal_ctrl;
          OFS_IRQ_EN:    rdata_q <= irq_en_q;
          OFS_BUS_SEL:   rdata_q <= ctrl_q.bus_sel;
          OFS_AUTO_CAL:  rdata_q <= ctrl_q.auto_cal;
          OFS_SPLL_LOCK: rdata_q <= {31'h0000_0000, stat_q.spll_lock};
          OFS_SUBSYSTEM_PLL_LOCK: rdata_q <= {31'h0000_0000, stat_q.subsystem_pll_lock};
          OFS_IRQ_STAT:  rdata_q <= {28'h000_0000, irq_st_q};
          OFS_CAL_STAT:  rdata_q <= stat_q.cal_stat;
          OFS_ALIGN_RST: rdata_q <= ctrl_q.align_rst;
          OFS_LOCK_CTRL: rdata_q <= {31'h0000_0000, lock_q};
          default:       rdata_q <= RD_UNMAPPED;
        endcase
      end
    end
  end

  assign o_readdata = rdata_q;
  assign o_response = 2'b00;
  assign o_ctrl     = ctrl_q;
  assign o_sub_sel  = sub_sel_q;
  assign o_irq      = irq_q;

  // assertions
  sequence s_locked_wr;
    i_write && ack_q && lock_q && i_address == OFS_RATIO;
  endsequence

  lock_blocks_wr_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    s_locked_wr |=> $stable(ctrl_q.ratio))
    else $error("locked write changed clock ratio");

  bus_answer_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(req) |=> !o_waitrequest)
    else $error("no answer one cycle after request");

  clk_gate_wr_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (sys_wr && i_address == OFS_CLK_GATE && i_byteenable == 4'hF)
    |=> o_ctrl.clk_gate == $past(i_writedata))
    else $error("clock gate write lost");

  bus_sel_wr_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (sys_wr && i_address == OFS_BUS_SEL && i_byteenable == 4'hF)
    |=> o_ctrl.bus_sel == $past(i_writedata))
    else $error("bus select write lost");

  rsv_read_zero_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (rd_go && i_address >= REG_RSV_LO) |=> o_readdata == RD_UNMAPPED)
    else $error("reserved read not zero");

  spll_stat_rd_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (rd_go && i_address == OFS_SPLL_LOCK)
    |=> o_readdata[0] == $past(stat_q.spll_lock))
    else $error("pll lock read wrong");

  irq_out_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    |(irq_st_q & irq_en_q[IRQ_N-1:0]) |=> o_irq)
    else $error("interrupt not raised");

  soft_rst_wr_a: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (sys_wr && i_address == OFS_SOFT_RST && i_byteenable == 4'hF)
    |=> o_ctrl.soft_rst == $past(i_writedata))
    else $error("soft reset write lost");

  pll_reset_val_a: assert property (
    @(posedge i_core_clk)
    $rose(i_rst_b) |-> o_ctrl.pll_upper == RST_PLL_UPPER
      || $past(sys_wr))
    else $error("pll upper reset value wrong");

endmodule : dsr_bank

// file: dsr_bank_tb_top.sv
// self-checking testbench for the system register bank
`timescale 1ns/1ps
module dsr_bank_tb_top
  import dsr_pkg::*;
;
  logic            clk;
  logic            rst_b;
  logic [AW-1:0]   av_addr;
  logic            av_rd;
  logic            av_wr;
  logic [DW-1:0]   av_wdata;
  logic [3:0]      av_be;
  logic [DW-1:0]   rdata;
  logic            waitreq;
  logic [1:0]      resp;
  logic            spll;
  logic            subsystem_pll;
  logic [DW-1:0]   cal;
  dsr_ctrl_t       ctrl;
  logic            sub_sel;
  logic            irq;
  int              bad_count;
  int              tests_run;
  int              sub_cnt;
  int              cycles;
  logic [DW-1:0]   q;
  logic [10:0]     rw_ofs [12];

  dsr_bank dsr_bank_i (
    .i_core_clk   (clk),
    .i_rst_b      (rst_b),
    .i_address    (av_addr),
    .i_read       (av_rd),
    .i_write      (av_wr),
    .i_writedata  (av_wdata),
    .i_byteenable (av_be),
    .o_readdata   (rdata),
    .o_waitrequest(waitreq),
    .o_response   (resp),
    .i_spll_lock  (spll),
    .i_subsystem_pll_lock  (subsystem_pll),
    .i_cal_stat   (cal),
    .o_ctrl       (ctrl),
    .o_sub_sel    (sub_sel),
    .o_irq        (irq)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (sub_sel === 1'b1) sub_cnt++;
    if (cycles == 6000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one avalon access, entered just after a rising edge
  task automatic bus(input logic wr, input logic [10:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    av_addr  <= a;
    av_wr    <= wr;
    av_rd    <= ~wr;
    av_wdata <= d;
    av_be    <= be;
    @(posedge clk);
    while (waitreq !== 1'b0) begin
      @(posedge clk);
    end
    q = rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr32(input logic [10:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr32

  task automatic rd_chk(input string what, input logic [10:0] a,
                        input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(what, exp, q);
  endtask : rd_chk

  task automatic t_reset();
    logic [31:0] e;
    for (int i = 0; i < 12; i++) begin
      e = (i == 1) ? RST_PLL_LOW_B : (i == 2) ? RST_PLL_UPPER : RST_ZERO;
      chk("ctrl reset", e, ctrl[383-32*i -: 32]);
      rd_chk("reg reset", rw_ofs[i], e);
    end
    rd_chk("irq enable reset", OFS_IRQ_EN, RST_ZERO);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_rw();
    logic [31:0] d;
    for (int i = 0; i < 12; i++) begin
      d = 32'hA5C3_0000 | 32'(i * 17 + 3);
      wr32(rw_ofs[i], d);
      chk("ctrl word", d, ctrl[383-32*i -: 32]);
      rd_chk("rw readback", rw_ofs[i], d);
    end
    bus(1'b1, OFS_PLL_LOW_A, 32'h1111_1111, 4'h1);
    rd_chk("byte lane", OFS_PLL_LOW_A, 32'hA5C3_0011);
    $display("test read-write registers done");
  endtask : t_rw

  task automatic t_decode();
    int c;
    c = sub_cnt;
    rd_chk("ctrl region", 11'h000, RD_UNMAPPED);
    wr32(11'h200, 32'hFFFF_FFFF);
    rd_chk("fic region", 11'h4FC, RD_UNMAPPED);
    chk("sub pulses", 32'd3, 32'(sub_cnt - c));
    c = sub_cnt;
    wr32(11'h600, 32'hFFFF_FFFF);
    wr32(11'h7FC, 32'hFFFF_FFFF);
    rd_chk("reserved low", 11'h600, RD_UNMAPPED);
    rd_chk("reserved high", 11'h7FC, RD_UNMAPPED);
    rd_chk("unmapped sys", 11'h538, RD_UNMAPPED);
    chk("no sub pulse", 32'd0, 32'(sub_cnt - c));
    chk("response", 32'd0, {30'd0, resp});
    $display("test region decode done");
  endtask : t_decode

  task automatic t_lock();
    wr32(OFS_LOCK_CTRL, 32'h0000_0001);
    wr32(OFS_RATIO, 32'h0000_0F0F);
    rd_chk("locked write", OFS_RATIO, 32'hA5C3_0058);
    rd_chk("lock event", OFS_IRQ_STAT, 32'h0000_0008);
    rd_chk("status cleared", OFS_IRQ_STAT, 32'h0000_0000);
    wr32(OFS_LOCK_CTRL, 32'h0000_0000);
    wr32(OFS_RATIO, 32'h0000_0F0F);
    rd_chk("unlocked write", OFS_RATIO, 32'h0000_0F0F);
    $display("test lock done");
  endtask : t_lock

  task automatic t_irq();
    wr32(OFS_IRQ_EN, 32'h0000_0001);
    rd_chk("irq enable", OFS_IRQ_EN, 32'h0000_0001);
    spll <= 1'b1;
    repeat (8) @(posedge clk);
    chk("irq raised", 32'd1, {31'd0, irq});
    rd_chk("spll status", OFS_SPLL_LOCK, 32'h0000_0001);
    rd_chk("irq status", OFS_IRQ_STAT, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'd0, {31'd0, irq});
    wr32(OFS_IRQ_EN, 32'h0000_0000);
    spll <= 1'b0;
    repeat (8) @(posedge clk);
    chk("irq masked", 32'd0, {31'd0, irq});
    rd_chk("masked status", OFS_IRQ_STAT, 32'h0000_0001);
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_ro();
    subsystem_pll <= 1'b1;
    cal  <= 32'h0000_0001;
    repeat (8) @(posedge clk);
    wr32(OFS_SUBSYSTEM_PLL_LOCK, 32'h0000_0000);
    wr32(OFS_CAL_STAT, 32'h0000_0000);
    wr32(OFS_SPLL_LOCK, 32'hFFFF_FFFF);
    rd_chk("spll lock", OFS_SPLL_LOCK, 32'h0000_0000);
    rd_chk("subsystem_pll lock", OFS_SUBSYSTEM_PLL_LOCK, 32'h0000_0001);
    rd_chk("cal status", OFS_CAL_STAT, 32'h0000_0001);
    rd_chk("events", OFS_IRQ_STAT, 32'h0000_0006);
    $display("test read-only registers done");
  endtask : t_ro

  task automatic t_mid_reset();
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("ctrl after reset", RST_PLL_UPPER, ctrl.pll_upper);
    chk("irq after reset", 32'd0, {31'd0, irq});
    chk("wait after reset", 32'd1, {31'd0, waitreq});
    $display("test mid-run reset done");
  endtask : t_mid_reset

  initial begin
    rw_ofs = '{OFS_PLL_LOW_A, OFS_PLL_LOW_B, OFS_PLL_UPPER, OFS_CLK_GATE,
               OFS_MUX_SEL, OFS_RATIO, OFS_DELAY_SEL, OFS_SOFT_RST,
               OFS_CAL_CTRL, OFS_BUS_SEL, OFS_AUTO_CAL, OFS_ALIGN_RST};
    bad_count = 0;
    tests_run = 0;
    sub_cnt   = 0;
    cycles    = 0;
    rst_b     = 1'b0;
    av_addr   = 11'h000;
    av_rd     = 1'b0;
    av_wr     = 1'b0;
    av_wdata  = 32'h0000_0000;
    av_be     = 4'hF;
    spll      = 1'b0;
    subsystem_pll      = 1'b0;
    cal       = 32'h0000_0000;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_rw();
    t_decode();
    t_lock();
    t_irq();
    t_ro();
    t_mid_reset();
    end_sim();
  end
endmodule : dsr_bank_tb_top
